// ==== rtl/wwd_pkg.sv ====
// Constants shared by the windowed watchdog modules.
// Assumes a single peripheral bus clock domain.
package wwd_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CONFIG = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam int START_BIT = 7;
  localparam int EARLY_WAKE_IRQ_ENABLE_BIT = 9;
  localparam int DIV_LSB = 7;
  localparam int FLAG_BIT = 0;
  localparam logic [6:0] COUNT_RESET = 7'h7f;
  localparam logic [6:0] WINDOW_RESET = 7'h7f;
  // ****************************************
  // Counter thresholds and time base
  // ****************************************
  localparam logic [6:0] COUNT_TRIP = 7'h40;
  localparam logic [6:0] COUNT_WARN = 7'h41;
  localparam int FIXED_DIV = 4096;
  localparam int MAX_DIV_SEL = 3;
  typedef enum logic [1:0] {
    WWD_SEL_NONE = 2'b00,
    WWD_SEL_CONTROL = 2'b01,
    WWD_SEL_CONFIG = 2'b10,
    WWD_SEL_STATUS = 2'b11
  } wwd_sel_t;
endpackage

// ==== rtl/wwd_tb_if.sv ====
// Link between the watchdog register block and its time-base divider.
// Assumes both ends share one clock.
interface wwd_tb_if;
  logic run;
  logic [1:0] div_sel;
  logic tick;
  modport ctrl (output run, output div_sel, input tick);
  modport base (input run, input div_sel, output tick);
endinterface

// ==== rtl/wwd_time_base.sv ====
// Time-base divider: bus clock / fixed divider / 2**div_sel, one-cycle tick.
// Assumes run and div_sel are synchronous to clk.
module wwd_time_base #(
  parameter int FIXED_DIV = wwd_pkg::FIXED_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  wwd_tb_if.base tb
);
  localparam int CW = $clog2(FIXED_DIV) + wwd_pkg::MAX_DIV_SEL + 1;
  localparam logic [CW-1:0] BASE_LAST = CW'(FIXED_DIV - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } wwd_tb_state_t;

  wwd_tb_state_t s;
  wwd_tb_state_t next_s;
  logic [CW-1:0] last;

  // The divider holds its phase while stopped so a debug halt does not
  // shorten the interval in progress.
  always_comb begin
    last = CW'(((BASE_LAST + CW'(1)) << tb.div_sel) - CW'(1));
    next_s = s;
    next_s.tick = 1'b0;
    if (tb.run) begin
      if (s.count >= last) begin
        next_s.count = '0;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = s.count + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tb.tick = s.tick;

  property p_tick_needs_run;
    @(posedge clk) disable iff (!rst_n)
    s.tick |-> $past(tb.run);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("Time-base tick without run.");
endmodule // wwd_time_base

// ==== rtl/wwd_watchdog.sv ====
// Windowed watchdog: 7-bit down counter, window check, early-wake flag.
// Assumes a peripheral bus slave port with byte strobes, one clock domain,
// and a system reset controller that pulls rst_n after wdg_reset_req.

// Functional notes
// - While enabled, counter stepping from 0x40 to 0x3F requests system reset.
// - While enabled, writing the counter while its value is above the window requests system reset.
// - Early-wake flag sets at count 0x40 and on a too-early refresh.
// - Interrupt asserts only when early-wake flag and its enable are set.
// - Writing zero to the status flag clears it and drops the interrupt.
// - Start bit 7 resets to zero, only software sets it, zero writes ignored.
// - Enabled counter decrements at bus clock / 4096 / 2**divider.
// - Two-bit divider code selects extra division by 1, 2, 4 or 8.
// - Timeout equals lower six counter bits plus one time-base periods.
// - Seven-bit window in configuration bits 6:0 limits refresh writes.
// - With freeze set, counting stops while the core is halted in debug.
// - Control and configuration accept 16-bit and 32-bit accesses.
// - Early-wake enable sits at configuration bit 9 and is set-only.
// - Control and configuration reset to 0x7F in low bits, rest zero.
// - Early-wake flag sets even with its interrupt enable clear.
// - Early-wake flag is status bit 0 at offset 0x08, rest read zero.
module wwd_watchdog #(
  parameter int FIXED_DIV = wwd_pkg::FIXED_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic debug_halted,
  input wire logic debug_halt_freeze,
  output logic wdg_reset_req,
  output logic early_wake_interrupt
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic watchdog_start_bit;
    logic [6:0] down_counter_value;
    logic [6:0] window_limit;
    logic [1:0] time_base_divider;
    logic early_wake_irq_enable;
    logic early_wake_flag;
    logic reset_req;
    logic irq;
    logic ready;
    logic [31:0] rdata;
    logic slverr;
  } wwd_state_t;

  wwd_state_t s;
  wwd_state_t next_s;
  wwd_tb_if tb ();

  wwd_time_base #(.FIXED_DIV(FIXED_DIV)) u_time_base (
    .clk(clk),
    .rst_n(rst_n),
    .tb(tb)
  );

  function automatic wwd_pkg::wwd_sel_t decode(input logic [3:0] addr);
    unique case (addr)
      wwd_pkg::OFF_CONTROL: decode = wwd_pkg::WWD_SEL_CONTROL;
      wwd_pkg::OFF_CONFIG: decode = wwd_pkg::WWD_SEL_CONFIG;
      wwd_pkg::OFF_STATUS: decode = wwd_pkg::WWD_SEL_STATUS;
      default: decode = wwd_pkg::WWD_SEL_NONE;
    endcase
  endfunction

  assign tb.run = s.watchdog_start_bit & ~(debug_halted & debug_halt_freeze);
  assign tb.div_sel = s.time_base_divider;

  // ****************************************
  // Next-state logic
  // ****************************************
  logic setup;
  logic wr;
  wwd_pkg::wwd_sel_t sel;
  logic refresh;
  logic early_refresh;
  logic step;

  always_comb begin
    setup = psel & ~penable;
    wr = psel & penable & pwrite & s.ready;
    sel = decode(paddr);
    refresh = wr && sel == wwd_pkg::WWD_SEL_CONTROL && pstrb[0];
    early_refresh = refresh && s.watchdog_start_bit &&
      s.down_counter_value > s.window_limit;
    // Gating on run as well stops the count in the very first frozen cycle; a tick
    // caught there is lost, which only stretches the interval under a debugger.
    step = tb.run && tb.tick && !refresh;
    next_s = s;
    next_s.reset_req = 1'b0;
    // A tick in the same cycle as a refresh is dropped: the refresh wins.
    if (step) begin
      next_s.down_counter_value = s.down_counter_value - 7'd1;
    end
    if (refresh) begin
      next_s.down_counter_value = pwdata[6:0];
      if (pwdata[wwd_pkg::START_BIT]) begin
        next_s.watchdog_start_bit = 1'b1;
      end
    end
    if (wr && sel == wwd_pkg::WWD_SEL_CONFIG) begin
      if (pstrb[0]) begin
        next_s.window_limit = pwdata[6:0];
        next_s.time_base_divider[0] = pwdata[wwd_pkg::DIV_LSB];
      end
      if (pstrb[1]) begin
        next_s.time_base_divider[1] = pwdata[wwd_pkg::DIV_LSB + 1];
        if (pwdata[wwd_pkg::EARLY_WAKE_IRQ_ENABLE_BIT]) begin
          next_s.early_wake_irq_enable = 1'b1;
        end
      end
    end
    // Clear first so that a same-cycle hardware set is not lost.
    if (wr && sel == wwd_pkg::WWD_SEL_STATUS && pstrb[0] && !pwdata[wwd_pkg::FLAG_BIT]) begin
      next_s.early_wake_flag = 1'b0;
    end
    if (step) begin
      if (s.down_counter_value == wwd_pkg::COUNT_WARN) begin
        next_s.early_wake_flag = 1'b1;
      end
      if (s.down_counter_value == wwd_pkg::COUNT_TRIP) begin
        next_s.reset_req = 1'b1;
      end
    end
    if (early_refresh) begin
      next_s.early_wake_flag = 1'b1;
      next_s.reset_req = 1'b1;
    end
    if (next_s.reset_req) begin
      next_s.watchdog_start_bit = 1'b0;
    end
    next_s.irq = next_s.early_wake_flag & next_s.early_wake_irq_enable;
    // Read data and ready are prepared in the setup phase so the access
    // phase completes with no wait state from registered outputs.
    next_s.ready = setup;
    next_s.slverr = setup && sel == wwd_pkg::WWD_SEL_NONE;
    next_s.rdata = '0;
    if (setup && !pwrite) begin
      unique case (sel)
        wwd_pkg::WWD_SEL_CONTROL: next_s.rdata = {24'h00_0000,
          s.watchdog_start_bit, s.down_counter_value};
        wwd_pkg::WWD_SEL_CONFIG: next_s.rdata = {22'h00_0000,
          s.early_wake_irq_enable, s.time_base_divider, s.window_limit};
        wwd_pkg::WWD_SEL_STATUS: next_s.rdata = {31'h0000_0000,
          s.early_wake_flag};
        wwd_pkg::WWD_SEL_NONE: next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.down_counter_value <= wwd_pkg::COUNT_RESET;
      s.window_limit <= wwd_pkg::WINDOW_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign pready = s.ready;
  assign prdata = s.rdata;
  assign pslverr = s.slverr;
  assign wdg_reset_req = s.reset_req;
  assign early_wake_interrupt = s.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_trip;
    step && s.down_counter_value == 7'h40
      |=> wdg_reset_req && s.down_counter_value == 7'h3f;
  endproperty
  a_trip: assert property (p_trip)
    else $error("No reset on 0x40 to 0x3F step.");

  property p_early;
    early_refresh |=> wdg_reset_req && s.early_wake_flag;
  endproperty
  a_early: assert property (p_early)
    else $error("Early refresh did not reset.");

  property p_warn;
    step && s.down_counter_value == 7'h41
      |=> s.early_wake_flag;
  endproperty
  a_warn: assert property (p_warn)
    else $error("Flag not set at 0x40.");

  property p_irq;
    early_wake_interrupt == (s.early_wake_flag && s.early_wake_irq_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt does not follow flag and enable.");

  property p_clear;
    wr && sel == wwd_pkg::WWD_SEL_STATUS && pstrb[0] && !pwdata[0] && !early_refresh
      && !(tb.tick && s.down_counter_value == 7'h41)
      |=> !s.early_wake_flag && !early_wake_interrupt;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Flag not cleared by zero write.");

  property p_start_sticky;
    s.watchdog_start_bit && !wdg_reset_req |=> s.watchdog_start_bit || wdg_reset_req;
  endproperty
  a_start_sticky: assert property (p_start_sticky)
    else $error("Start bit cleared without reset request.");

  property p_freeze;
    debug_halted && debug_halt_freeze && !refresh |=>
      $stable(s.down_counter_value);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Counter moved while frozen.");

  property p_pulse;
    wdg_reset_req |-> !s.watchdog_start_bit ##1 !wdg_reset_req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("Reset request not a one-cycle pulse.");

  property p_status_read;
    setup && !pwrite && sel == wwd_pkg::WWD_SEL_STATUS |=> prdata[31:1] == 31'h0000_0000;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status reserved bits not zero.");
endmodule // wwd_watchdog

// ==== verif/test_wwd_watchdog.sv ====
// Self-checking bench for the windowed watchdog register block.
// Assumes the zero-wait register handshake and a shortened fixed divider.
module test_wwd_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FD = 4;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic debug_halted, debug_halt_freeze, wdg_reset_req, early_wake_interrupt;
  logic [3:0] paddr, pstrb;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int n, miscompares, checks_done;
  wwd_watchdog #(.FIXED_DIV(FD)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .debug_halted(debug_halted),
    .debug_halt_freeze(debug_halt_freeze), .wdg_reset_req(wdg_reset_req),
    .early_wake_interrupt(early_wake_interrupt));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    q = prdata;
    e = pslverr;
    chk(32'(k < 8), 32'h1);
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(q, exp);
  endtask
  // Counts cycles from the last write edge until the chosen output is seen high.
  task automatic wait_for(input bit irq, input int hi);
    n = 0;
    do begin @(negedge clk); n++; end
    while ((irq ? early_wake_interrupt : wdg_reset_req) !== 1'b1 && n <= hi);
  endtask
  task automatic in_range(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 4'h0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    debug_halted = 1'b0;
    debug_halt_freeze = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(wwd_pkg::OFF_CONTROL, 32'h0000_007f);
    rd(wwd_pkg::OFF_CONFIG, 32'h0000_007f);
    rd(wwd_pkg::OFF_STATUS, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    chk(32'(e), 32'h1);
    // Expiry with the interrupt disabled still raises the flag.
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00c1, 4'hf);
    wait_for(1'b0, 2 * FD + 2);
    in_range(FD, 2 * FD + 2);
    chk(32'(early_wake_interrupt), 32'h0);
    @(negedge clk);
    chk(32'(wdg_reset_req), 32'h0);
    rd(wwd_pkg::OFF_CONTROL, 32'h0000_003f);
    rd(wwd_pkg::OFF_STATUS, 32'h0000_0001);
    wr(wwd_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
    rd(wwd_pkg::OFF_STATUS, 32'h0000_0000);
    wr(wwd_pkg::OFF_CONFIG, 32'h0000_0250, 4'h3);
    rd(wwd_pkg::OFF_CONFIG, 32'h0000_0250);
    wr(wwd_pkg::OFF_CONFIG, 32'h0000_00ff, 4'hf);
    rd(wwd_pkg::OFF_CONFIG, 32'h0000_02ff);
    wr(wwd_pkg::OFF_CONFIG, 32'h0000_0300, 4'hc);
    rd(wwd_pkg::OFF_CONFIG, 32'h0000_02ff);
    // Slowest base so the flag clear lands well before expiry.
    wr(wwd_pkg::OFF_CONFIG, 32'h0000_03ff, 4'hf);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00c1, 4'hf);
    wait_for(1'b1, 8 * FD + 2);
    in_range(1, 8 * FD + 2);
    wr(wwd_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
    // The clear lands on the write edge, so look half a cycle later.
    @(negedge clk);
    chk(32'(early_wake_interrupt), 32'h0);
    wait_for(1'b0, 8 * FD + 2);
    in_range(1, 8 * FD + 2);
    for (int p = 0; p < 4; p++) begin
      wr(wwd_pkg::OFF_CONFIG, 32'h0000_007f | (32'(p) << 7), 4'hf);
      wr(wwd_pkg::OFF_CONTROL, 32'h0000_00c2, 4'hf);
      wait_for(1'b0, 3 * (FD << p) + 2);
      in_range(2 * (FD << p), 3 * (FD << p) + 2);
    end
    // A refresh above the window trips at once.
    wr(wwd_pkg::OFF_CONFIG, 32'h0000_0050, 4'hf);
    wr(wwd_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00ff, 4'hf);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00ff, 4'hf);
    wait_for(1'b0, 3);
    in_range(1, 3);
    rd(wwd_pkg::OFF_STATUS, 32'h0000_0001);
    chk(32'(early_wake_interrupt), 32'h1);
    // A refresh at the window value is accepted.
    wr(wwd_pkg::OFF_STATUS, 32'h0000_0000, 4'hf);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00d0, 4'hf);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00d0, 4'hf);
    wait_for(1'b0, 17 * FD + 2);
    in_range(15 * FD, 17 * FD + 2);
    // Freeze while halted, then run on with the freeze control clear.
    @(posedge clk);
    debug_halt_freeze <= 1'b1;
    debug_halted <= 1'b1;
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_00c1, 4'hf);
    repeat (10 * FD) @(posedge clk);
    rd(wwd_pkg::OFF_CONTROL, 32'h0000_00c1);
    wr(wwd_pkg::OFF_CONTROL, 32'h0000_0045, 4'hf);
    rd(wwd_pkg::OFF_CONTROL, 32'h0000_00c5);
    debug_halt_freeze <= 1'b0;
    wait_for(1'b0, 6 * FD + 3);
    in_range(5 * FD, 6 * FD + 3);
    finish_test();
  end
endmodule // test_wwd_watchdog
